/* logic/fcd_host_ctrl.sv */
// Host controller that issues flash command sequences from registers
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module fcd_host_ctrl (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata,
  // Flash pins
  output wire logic [19:0] flashAddr,
  output wire logic [15:0] flashDqOut,
  output wire logic        flashDqOe,
  input  wire logic [15:0] flashDqIn,
  output wire logic        flashCeN,
  output wire logic        flashWeN,
  output wire logic        flashOeN,
  output logic             flashByteN,
  input  wire logic        readyBusyN
);
  typedef struct packed {
    fcd_pkg::fcd_op_e op;
    logic [2:0]       idx;
    logic [19:0]      addr;
    logic [15:0]      data;
    logic             byteMode;
    logic             busy;
    logic             req;
    logic             suspended;
    logic             bypass;
    logic             autosel;
    logic             err;
    logic [15:0]      rdData;
    logic [31:0]      rdOut;
    logic             ryb1;
    logic             ryb2;
  } fcd_ctrl_s;
  fcd_ctrl_s s_q, s_d;
  fcd_pkg::fcd_step_s cur;
  fcd_pkg::fcd_op_e   newOp;
  fcd_bus_if          bus ();

  function automatic fcd_pkg::fcd_step_s seqStep(fcd_pkg::fcd_op_e op,
      logic [2:0] idx, logic byteMode, logic [19:0] a, logic [15:0] d);
    fcd_pkg::fcd_step_s r;
    logic [19:0] u1;
    logic [19:0] u2;
    logic [15:0] third;
    logic        erase;
    u1 = byteMode ? fcd_pkg::UNLOCK1_BYTE : fcd_pkg::UNLOCK1_WORD;
    u2 = byteMode ? fcd_pkg::UNLOCK2_BYTE : fcd_pkg::UNLOCK2_WORD;
    erase = (op == fcd_pkg::OP_CHIP_ERASE) || (op == fcd_pkg::OP_SECT_ERASE);
    case (op)
      fcd_pkg::OP_PROG:      third = fcd_pkg::CODE_PROGRAM;
      fcd_pkg::OP_BYP_ENTER: third = fcd_pkg::CODE_BYPASS;
      fcd_pkg::OP_AUTOSEL:   third = fcd_pkg::CODE_AUTOSEL;
      default:               third = fcd_pkg::CODE_ERASE;
    endcase
    r = '{addr: 20'h00000, data: 16'h0000, isRead: 1'b0, last: 1'b1};
    case (op)
      fcd_pkg::OP_RESET:   r.data = fcd_pkg::CODE_RESET;
      fcd_pkg::OP_SUSPEND: r.data = fcd_pkg::CODE_SUSPEND;
      fcd_pkg::OP_RESUME:  r.data = fcd_pkg::CODE_RESUME;
      fcd_pkg::OP_SECT_ADD: begin
        r.addr = a;
        r.data = fcd_pkg::CODE_SECTOR;
      end
      fcd_pkg::OP_READ: begin
        r.addr   = a;
        r.isRead = 1'b1;
      end
      fcd_pkg::OP_BYP_PROG: begin
        if (idx == 3'h0) begin
          r.data = fcd_pkg::CODE_PROGRAM;
          r.last = 1'b0;
        end else begin
          r.addr = a;
          r.data = d;
        end
      end
      fcd_pkg::OP_BYP_EXIT: begin
        if (idx == 3'h0) begin
          r.data = fcd_pkg::CODE_AUTOSEL;
          r.last = 1'b0;
        end else begin
          r.data = fcd_pkg::CODE_BYP_EXIT;
        end
      end
      default: begin
        case (idx)
          3'h0: begin
            r.addr = u1;
            r.data = fcd_pkg::CODE_UNLOCK1;
            r.last = 1'b0;
          end
          3'h1: begin
            r.addr = u2;
            r.data = fcd_pkg::CODE_UNLOCK2;
            r.last = 1'b0;
          end
          3'h2: begin
            r.addr = u1;
            r.data = third;
            r.last = (op == fcd_pkg::OP_BYP_ENTER)
                  || (op == fcd_pkg::OP_AUTOSEL);
          end
          3'h3: begin
            if (erase) begin
              r.addr = u1;
              r.data = fcd_pkg::CODE_UNLOCK1;
              r.last = 1'b0;
            end else begin
              r.addr = a;
              r.data = d;
            end
          end
          3'h4: begin
            r.addr = u2;
            r.data = fcd_pkg::CODE_UNLOCK2;
            r.last = 1'b0;
          end
          default: begin
            // Chip erase at the unlock address, sector erase at its sector
            r.addr = (op == fcd_pkg::OP_CHIP_ERASE) ? u1 : a;
            r.data = (op == fcd_pkg::OP_CHIP_ERASE) ? fcd_pkg::CODE_CHIP
                                                    : fcd_pkg::CODE_SECTOR;
          end
        endcase
      end
    endcase
    return r;
  endfunction

  // Keeps the device out of sequences it would only ignore or abort on
  function automatic logic opLegal(fcd_pkg::fcd_op_e op, logic susp,
      logic byp, logic asel);
    logic ok;
    ok = 1'b1;
    if (op > fcd_pkg::OP_READ) begin
      ok = 1'b0;
    end else if (byp) begin
      ok = op inside {fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT,
                      fcd_pkg::OP_READ};
    end else if (asel) begin
      ok = op inside {fcd_pkg::OP_RESET, fcd_pkg::OP_READ};
    end else if (susp) begin
      ok = op inside {fcd_pkg::OP_PROG, fcd_pkg::OP_AUTOSEL,
                      fcd_pkg::OP_RESET, fcd_pkg::OP_RESUME,
                      fcd_pkg::OP_READ};
    end else begin
      ok = !(op inside {fcd_pkg::OP_BYP_PROG, fcd_pkg::OP_BYP_EXIT,
                        fcd_pkg::OP_RESUME});
    end
    return ok;
  endfunction

  assign cur        = seqStep(s_q.op, s_q.idx, s_q.byteMode, s_q.addr,
                              s_q.data);
  assign newOp      = fcd_pkg::fcd_op_e'(regWdata[3:0]);
  assign bus.req    = s_q.req;
  assign bus.isRead = cur.isRead;
  assign bus.addr   = cur.addr;
  assign bus.wdata  = cur.data;

  always_comb begin
    s_d       = s_q;
    s_d.req   = 1'b0;
    s_d.rdOut = 32'h00000000;
    s_d.ryb1  = readyBusyN;
    s_d.ryb2  = s_q.ryb1;
    if (regRead) begin
      case (regAddr)
        fcd_pkg::REG_CTRL:   s_d.rdOut = {23'h000000, s_q.byteMode,
                                          4'h0, s_q.op};
        fcd_pkg::REG_ADDR:   s_d.rdOut = {12'h000, s_q.addr};
        fcd_pkg::REG_DATA:   s_d.rdOut = {16'h0000, s_q.data};
        fcd_pkg::REG_STATUS: s_d.rdOut = {26'h0000000, s_q.ryb2,
                                          s_q.autosel, s_q.bypass,
                                          s_q.suspended, s_q.err, s_q.busy};
        fcd_pkg::REG_RDATA:  s_d.rdOut = {16'h0000, s_q.rdData};
        default:             s_d.rdOut = 32'h00000000;
      endcase
    end
    // Clear first so that a refusal in the same cycle still sets it
    if (regWrite && regAddr == fcd_pkg::REG_STATUS
        && regWdata[fcd_pkg::ST_ERR_BIT]) begin
      s_d.err = 1'b0;
    end
    if (regWrite && regAddr != fcd_pkg::REG_STATUS) begin
      if (s_q.busy) begin
        s_d.err = 1'b1;
      end else if (regAddr == fcd_pkg::REG_ADDR) begin
        s_d.addr = regWdata[19:0];
      end else if (regAddr == fcd_pkg::REG_DATA) begin
        s_d.data = regWdata[15:0];
      end else if (regAddr == fcd_pkg::REG_CTRL) begin
        if (opLegal(newOp, s_q.suspended, s_q.bypass, s_q.autosel)) begin
          s_d.op       = newOp;
          s_d.byteMode = regWdata[fcd_pkg::CTRL_BYTE_BIT];
          s_d.idx      = 3'h0;
          s_d.busy     = 1'b1;
          s_d.req      = 1'b1;
        end else begin
          s_d.err = 1'b1;
        end
      end
    end
    if (s_q.busy && bus.done) begin
      if (cur.last) begin
        s_d.busy = 1'b0;
        case (s_q.op)
          fcd_pkg::OP_SUSPEND:   s_d.suspended = 1'b1;
          fcd_pkg::OP_RESUME:    s_d.suspended = 1'b0;
          fcd_pkg::OP_BYP_ENTER: s_d.bypass = 1'b1;
          fcd_pkg::OP_BYP_EXIT:  s_d.bypass = 1'b0;
          fcd_pkg::OP_AUTOSEL:   s_d.autosel = 1'b1;
          fcd_pkg::OP_RESET:     s_d.autosel = 1'b0;
          fcd_pkg::OP_READ:      s_d.rdData = bus.rdata;
          default:               s_d.busy = 1'b0;
        endcase
      end else begin
        s_d.idx = s_q.idx + 3'h1;
        s_d.req = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata   = s_q.rdOut;
  assign flashByteN = !s_q.byteMode;

  fcd_bus_cycle u_cycle (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .bus        (bus.eng),
    .flashAddr  (flashAddr),
    .flashDqOut (flashDqOut),
    .flashDqOe  (flashDqOe),
    .flashDqIn  (flashDqIn),
    .flashCeN   (flashCeN),
    .flashWeN   (flashWeN),
    .flashOeN   (flashOeN)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence exitDone;
    bus.done && s_q.op == fcd_pkg::OP_BYP_EXIT && s_q.idx == 3'h1;
  endsequence
  sequence autoDone;
    bus.done && s_q.op == fcd_pkg::OP_AUTOSEL && s_q.idx == 3'h2;
  endsequence

  susp_single_a: assert property (
    bus.req && s_q.op == fcd_pkg::OP_SUSPEND
    |-> bus.wdata == 16'h00b0 && cur.last && !bus.isRead)
    else $error("suspend is not a single B0 write");
  resume_gate_a: assert property (
    $rose(s_q.busy) && s_q.op == fcd_pkg::OP_RESUME |-> s_q.suspended
      && bus.wdata == 16'h0030)
    else $error("resume issued while not suspended");
  unlock_word_a: assert property (
    bus.req && s_q.op == fcd_pkg::OP_PROG && !s_q.byteMode
    && s_q.idx == 3'h1 |-> bus.addr == 20'h002aa && bus.wdata == 16'h0055)
    else $error("second unlock cycle wrong");
  prog_data_a: assert property (
    bus.req && s_q.op == fcd_pkg::OP_PROG && s_q.idx == 3'h3
    |-> bus.addr == s_q.addr && bus.wdata == s_q.data && cur.last)
    else $error("program cycle carries wrong address or data");
  erase_setup_a: assert property (
    bus.req && s_q.op == fcd_pkg::OP_CHIP_ERASE
    |-> (s_q.idx == 3'h2) == (bus.wdata == 16'h0080)
      && (s_q.idx == 3'h5) == (bus.wdata == 16'h0010))
    else $error("erase sequence codes wrong");
  autosel_mode_a: assert property (
    autoDone |=> s_q.autosel && !s_q.busy)
    else $error("autoselect not entered after code 90");
  bypass_prog_a: assert property (
    s_q.busy && s_q.op == fcd_pkg::OP_BYP_PROG |-> s_q.bypass)
    else $error("bypass program outside bypass mode");
  bypass_exit_a: assert property (
    exitDone |=> !s_q.bypass ##1 !s_q.busy)
    else $error("bypass mode not left after 90 then 00");
endmodule
`default_nettype wire

/* logic/fcd_pkg.sv */
// Constants and types of the host-side flash command controller
// Function
// - Erase suspend is one write of data B0, any address.
// - Resume is one write of data 30 at any address, only while suspended.
// - Unlock: AA at 555 then 55 at 2AA; byte mode AAA and 555.
// - Program: two unlocks, A0, then program address with program data.
// - Erase: unlock, 80, unlock, then 10 at unlock address or 30 at sector.
// - Autoselect: two unlocks, 90, then a read selected by address.
// - Bypass entered by unlocks plus 20; then A0 and address with data programs.
// - Bypass left by 90 then 00 at any addresses.
`default_nettype none
package fcd_pkg;
  // Bus cycle timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SETUP_NS    = 10;
  localparam int T_PULSE_NS    = 35;
  localparam int T_HOLD_NS     = 20;
  localparam int T_READ_NS     = 70;
  localparam int SYNC_STAGES   = 2;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC  = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC  = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                             + SYNC_STAGES;
  // Command codes on the flash data bus
  localparam logic [15:0] CODE_RESET    = 16'h00f0;
  localparam logic [15:0] CODE_UNLOCK1  = 16'h00aa;
  localparam logic [15:0] CODE_UNLOCK2  = 16'h0055;
  localparam logic [15:0] CODE_PROGRAM  = 16'h00a0;
  localparam logic [15:0] CODE_BYPASS   = 16'h0020;
  localparam logic [15:0] CODE_AUTOSEL  = 16'h0090;
  localparam logic [15:0] CODE_BYP_EXIT = 16'h0000;
  localparam logic [15:0] CODE_ERASE    = 16'h0080;
  localparam logic [15:0] CODE_CHIP     = 16'h0010;
  localparam logic [15:0] CODE_SECTOR   = 16'h0030;
  localparam logic [15:0] CODE_SUSPEND  = 16'h00b0;
  localparam logic [15:0] CODE_RESUME   = 16'h0030;
  // Unlock addresses
  localparam logic [19:0] UNLOCK1_WORD = 20'h00555;
  localparam logic [19:0] UNLOCK2_WORD = 20'h002aa;
  localparam logic [19:0] UNLOCK1_BYTE = 20'h00aaa;
  localparam logic [19:0] UNLOCK2_BYTE = 20'h00555;
  // Register offsets and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int CTRL_BYTE_BIT = 8;
  localparam int ST_ERR_BIT    = 1;
  // Operations
  typedef enum logic [3:0] {
    OP_RESET      = 4'h0,
    OP_PROG       = 4'h1,
    OP_BYP_ENTER  = 4'h2,
    OP_BYP_PROG   = 4'h3,
    OP_BYP_EXIT   = 4'h4,
    OP_CHIP_ERASE = 4'h5,
    OP_SECT_ERASE = 4'h6,
    OP_SECT_ADD   = 4'h7,
    OP_SUSPEND    = 4'h8,
    OP_RESUME     = 4'h9,
    OP_AUTOSEL    = 4'ha,
    OP_READ       = 4'hb
  } fcd_op_e;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        isRead;
    logic        last;
  } fcd_step_s;
endpackage
`default_nettype wire

/* logic/fcd_bus_if.sv */
// Request channel between the sequencer and the bus cycle engine
`default_nettype none
interface fcd_bus_if;
  logic        req;
  logic        isRead;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctl (output req, isRead, addr, wdata, input done, rdata);
  modport eng (input req, isRead, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* logic/fcd_bus_cycle.sv */
// One flash bus cycle, write or read, on the parallel pins
`default_nettype none
module fcd_bus_cycle (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Requests
  fcd_bus_if.eng           bus,
  // Flash pins
  output logic [19:0]      flashAddr,
  output logic [15:0]      flashDqOut,
  output logic             flashDqOe,
  input  wire logic [15:0] flashDqIn,
  output logic             flashCeN,
  output logic             flashWeN,
  output logic             flashOeN
);
  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_PULSE = 2'b11,
    CY_HOLD  = 2'b10
  } fcd_cyc_e;
  typedef struct packed {
    fcd_cyc_e    st;
    logic [5:0]  cnt;
    logic        isRead;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        ceN;
    logic        weN;
    logic        oeN;
    logic        dqOe;
    logic        done;
    logic [15:0] rdata;
    logic [15:0] dqSync1;
    logic [15:0] dqSync2;
  } fcd_cyc_s;
  localparam fcd_cyc_s CYC_RESET = '{st: CY_IDLE, cnt: 6'h00, isRead: 1'b0,
    addr: 20'h00000, wdata: 16'h0000, ceN: 1'b1, weN: 1'b1, oeN: 1'b1,
    dqOe: 1'b0, done: 1'b0, rdata: 16'h0000, dqSync1: 16'h0000,
    dqSync2: 16'h0000};
  fcd_cyc_s s_q, s_d;

  always_comb begin
    s_d         = s_q;
    s_d.done    = 1'b0;
    s_d.dqSync1 = flashDqIn;
    s_d.dqSync2 = s_q.dqSync1;
    case (s_q.st)
      CY_IDLE: begin
        if (bus.req) begin
          s_d.st     = CY_SETUP;
          s_d.addr   = bus.addr;
          s_d.wdata  = bus.wdata;
          s_d.isRead = bus.isRead;
          s_d.ceN    = 1'b0;
          s_d.dqOe   = !bus.isRead;
          s_d.cnt    = 6'(fcd_pkg::SETUP_CYC);
        end
      end
      CY_SETUP: begin
        // Address settles before the strobe falls
        if (s_q.cnt <= 6'h01) begin
          s_d.st = CY_PULSE;
          if (s_q.isRead) begin
            s_d.oeN = 1'b0;
            s_d.cnt = 6'(fcd_pkg::READ_CYC);
          end else begin
            s_d.weN = 1'b0;
            s_d.cnt = 6'(fcd_pkg::PULSE_CYC);
          end
        end else begin
          s_d.cnt = s_q.cnt - 6'h01;
        end
      end
      CY_PULSE: begin
        if (s_q.cnt <= 6'h01) begin
          s_d.st  = CY_HOLD;
          s_d.weN = 1'b1;
          s_d.oeN = 1'b1;
          s_d.cnt = 6'(fcd_pkg::HOLD_CYC);
          // Read time already covers the two sampling stages
          if (s_q.isRead) begin
            s_d.rdata = s_q.dqSync2;
          end
        end else begin
          s_d.cnt = s_q.cnt - 6'h01;
        end
      end
      CY_HOLD: begin
        // Data still driven after the strobe rises
        if (s_q.cnt <= 6'h01) begin
          s_d.st   = CY_IDLE;
          s_d.ceN  = 1'b1;
          s_d.dqOe = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 6'h01;
        end
      end
      default: s_d = CYC_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= CYC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.done   = s_q.done;
  assign bus.rdata  = s_q.rdata;
  assign flashAddr  = s_q.addr;
  assign flashDqOut = s_q.wdata;
  assign flashDqOe  = s_q.dqOe;
  assign flashCeN   = s_q.ceN;
  assign flashWeN   = s_q.weN;
  assign flashOeN   = s_q.oeN;
endmodule
`default_nettype wire

/* tb/fcd_flash_model.sv */
// Behavioural flash device that answers the host controller's bus cycles
`default_nettype none
module fcd_flash_model #(
  parameter logic [15:0] MFG_CODE = 16'h00c3, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0c3c, // Arbitrary value
  parameter int          BUSY_NS  = 4000
) (
  // Bus pins
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic        byteN,
  // Read data and ready pull-down
  output logic [15:0]      dqOut,
  output logic             rbLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [19:0] a;
  logic [19:0] msk;
  logic [15:0] val;
  logic [15:0] lastDrv = 16'h0000;
  logic [6:0]  sect = 7'h00;
  logic [7:0]  d;
  logic        bypass = 1'b0;
  logic        autosel = 1'b0;
  logic        susp = 1'b0;
  logic        erasing = 1'b0;
  logic        prog = 1'b0;
  logic        tog = 1'b0;
  int          n = 0;
  int          eraseLeft = 0;
  int          progLeft = 0;
  int          chipLeft = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // Erase time stands still while suspended
  always #20 begin
    if (erasing) eraseLeft -= 20;
    if (eraseLeft <= 0) erasing = 1'b0;
    if (progLeft > 0) progLeft -= 20;
    if (chipLeft > 0) chipLeft -= 20;
  end
  assign rbLow = erasing || progLeft > 0 || chipLeft > 0;
  assign msk = byteN ? 20'h007ff : 20'h00fff;
  always @(negedge weN) if (!ceN) a = addr;
  always @(negedge ceN) if (!weN) a = addr;
  always @(posedge weN) if (!ceN) cmd(dq);
  always @(posedge ceN) if (!weN) cmd(dq);
  task cmd(input logic [15:0] w);
    d = w[7:0];
    if (progLeft > 0 || chipLeft > 0) d = 8'hff;
    else if (prog) begin
      mem[a[7:0]] = w;
      prog = 1'b0;
      progLeft = 400;
    end
    else if (erasing) begin
      if (d == 8'hb0) susp = 1'b1;
      erasing = !susp;
    end
    else if (bypass) begin
      if (n == 9 && d == 8'h00) bypass = 1'b0;
      prog = d == 8'ha0;
      n = d == 8'h90 ? 9 : 0;
    end
    else if (d == 8'h30 && susp && n == 0) begin
      susp = 1'b0;
      erasing = 1'b1;
    end
    else if (d == 8'hf0) begin
      autosel = 1'b0;
      n = 0;
    end
    else if (n == 0 && d == 8'haa && (a & msk) == (byteN ? 'h555 : 'haaa))
      n = 1;
    else if (n == 1 && d == 8'h55 && (a & msk) == (byteN ? 'h2aa : 'h555))
      n = 2;
    else if (n == 2 && (a & msk) == (byteN ? 'h555 : 'haaa)) begin
      n = (d == 8'h80 && !susp) ? 3 : 0;
      prog = d == 8'ha0;
      autosel = autosel || d == 8'h90;
      bypass = d == 8'h20 && !susp;
    end
    else if (n == 3 && d == 8'haa) n = 4;
    else if (n == 4 && d == 8'h55) n = 5;
    else if (n == 5 && d == 8'h30) begin
      sect = a[18:12];
      erasing = 1'b1;
      eraseLeft = BUSY_NS;
      n = 0;
    end
    else if (n == 5 && d == 8'h10) begin
      foreach (mem[i]) mem[i] = 16'hffff;
      chipLeft = BUSY_NS;
      n = 0;
    end
    else n = 0;
  endtask
  // Identification beats status, status beats array contents
  always_comb begin
    if (autosel && addr[7:0] == 8'h00) val = MFG_CODE;
    else if (autosel && addr[7:0] == (byteN ? 8'h01 : 8'h02)) val = DEV_CODE;
    else if (autosel) val = 16'h0000;
    else if (susp && addr[18:12] == sect) val = {8'h00, 5'h10, tog, 2'h0};
    else val = mem[addr[7:0]];
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign dqOut = (!ceN && !oeN) ? val : ~lastDrv;
  always @(posedge oeN) lastDrv = val;
  always @(negedge oeN) tog = ~tog;
endmodule
`default_nettype wire

/* tb/fcd_host_ctrl_tb.sv */
// Self-checking bench for the host-side flash command controller
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, (g), (e)); end end
module fcd_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MFG = 16'h00c3; // Arbitrary value
  localparam logic [15:0] DEV = 16'h0c3c; // Arbitrary value
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] st;
  logic [19:0] flashAddr;
  logic [15:0] flashDqOut;
  logic [15:0] flashDqIn;
  logic [15:0] modelDq;
  logic        flashDqOe, flashCeN, flashWeN, flashOeN, flashByteN, rbLow;
  logic        readyBusyN;
  int          n_fail = 0;
  int          total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  // Shared data lines and pulled-up ready line
  assign flashDqIn = flashDqOe ? flashDqOut : modelDq;
  assign readyBusyN = !rbLow;
  fcd_host_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .flashByteN(flashByteN), .readyBusyN(readyBusyN));
  fcd_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV), .BUSY_NS(4000)) u_flash (
    .addr(flashAddr), .dq(flashDqIn), .ceN(flashCeN), .weN(flashWeN),
    .oeN(flashOeN), .byteN(flashByteN), .dqOut(modelDq), .rbLow(rbLow));
  task automatic complete_run();
    $display("Checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // Polls are bounded; running out ends the run as a failure
  task automatic waitSt(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 3000; i++) begin
      rd(fcd_pkg::REG_STATUS, st);
      if ((st & m) === v) return;
    end
    n_fail++;
    $display("ERROR %0t status wait timed out", $time);
    complete_run();
  endtask
  task automatic op(input logic [3:0] o, input logic [19:0] ad,
                    input logic [15:0] dt, input logic bm = 1'b0);
    wr(fcd_pkg::REG_ADDR, {12'h000, ad});
    wr(fcd_pkg::REG_DATA, {16'h0000, dt});
    wr(fcd_pkg::REG_CTRL, {23'h0, bm, 4'h0, o});
    waitSt(32'h1, 32'h0);
  endtask
  task automatic pg(input logic [3:0] o, input logic [19:0] ad,
                    input logic [15:0] dt, input logic bm = 1'b0);
    op(o, ad, dt, bm);
    waitSt(32'h20, 32'h20);
  endtask
  task automatic rf(input logic [19:0] ad, input logic [15:0] m,
                    input logic [15:0] e, input logic bm = 1'b0);
    op(4'hb, ad, 16'h0000, bm);
    rd(fcd_pkg::REG_RDATA, st);
    `CHK(st & {16'h0, m}, {16'h0, e})
  endtask
  task automatic cs(input logic [31:0] m, input logic [31:0] e);
    rd(fcd_pkg::REG_STATUS, st);
    `CHK(st & m, e)
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Ready line shows in status only after its two sync stages
    repeat (2) @(posedge clk_sys);
    cs(32'hffffffff, 32'h20);
    rd(8'h14, st);
    `CHK(st, 32'h0)
    $display("Test reset done");
    pg(4'h1, 20'h00010, 16'h1234);
    rf(20'h00010, 16'hffff, 16'h1234);
    pg(4'h1, 20'h00041, 16'hff5a, 1'b1);
    rf(20'h00041, 16'h00ff, 16'h005a, 1'b1);
    $display("Test program done");
    op(4'h6, 20'h03000, 16'h0000);
    op(4'h7, 20'h05000, 16'h0000);
    op(4'h8, 20'h00000, 16'h0000);
    cs(32'h3f, 32'h24);
    rf(20'h03010, 16'h0080, 16'h0080);
    pg(4'h1, 20'h00020, 16'habcd);
    rf(20'h00020, 16'hffff, 16'habcd);
    op(4'ha, 20'h00000, 16'h0000);
    rf(20'h03000, 16'hffff, MFG);
    rf(20'h03001, 16'hffff, DEV);
    rf(20'h03002, 16'hffff, 16'h0000);
    op(4'h0, 20'h00000, 16'h0000);
    cs(32'h1c, 32'h04);
    op(4'h9, 20'h00000, 16'h0000);
    cs(32'h24, 32'h00);
    op(4'h9, 20'h00000, 16'h0000);
    cs(32'h02, 32'h02);
    wr(fcd_pkg::REG_STATUS, 32'h2);
    op(4'h8, 20'h00000, 16'h0000);
    cs(32'h26, 32'h24);
    op(4'h9, 20'h00000, 16'h0000);
    waitSt(32'h20, 32'h20);
    $display("Test suspend done");
    op(4'h2, 20'h00000, 16'h0000);
    pg(4'h3, 20'h00030, 16'h5555);
    op(4'h1, 20'h00030, 16'h0000);
    cs(32'h0a, 32'h0a);
    wr(fcd_pkg::REG_STATUS, 32'h2);
    op(4'h4, 20'h00000, 16'h0000);
    cs(32'h0a, 32'h00);
    rf(20'h00030, 16'hffff, 16'h5555);
    $display("Test bypass done");
    op(4'h5, 20'h00000, 16'h0000);
    op(4'h8, 20'h00000, 16'h0000);
    cs(32'h20, 32'h00);
    waitSt(32'h20, 32'h20);
    rf(20'h00010, 16'hffff, 16'hffff);
    $display("Test chip erase done");
    complete_run();
  end
endmodule
`default_nettype wire
